// ===== verif/adc_spi_host_model.sv
/*
 * Host controller model: SPI master in mode 3 driving the serial port.
 * Assumes: CLK is the 100 MHz bench clock; SCLK half period is 8 CLK (80 ns).
 */
`timescale 1ns/1ns
module adc_spi_host_model (
    input wire logic CLK, // bench clock, paces the host
    output logic SCLK, // serial clock, stands high outside frames
    output logic CHIP_SELECT_LOW, // select, active low
    output logic SDI, // host data towards the device
    input wire logic SDO // device data towards the host
);
    initial begin
        SCLK = 1'b1;
        CHIP_SELECT_LOW = 1'b1;
        SDI = 1'b0;
    end

    // ==========================================================
    // helpers
    task automatic wait_clk(input int n);
        repeat (n) @(negedge CLK);
    endtask

    // released data line shows the inverse so a stale bit is never trusted
    task automatic release_sel(input int n);
        CHIP_SELECT_LOW = 1'b1;
        SDI = ~SDI;
        wait_clk(n);
    endtask

    // ==========================================================
    // one byte; bits below 8 abort the byte by releasing select early
    // select held for the byte
    // change on falling, capture on rising
    task automatic xfer(input logic [7:0] tx, input bit gap, input int bits,
                        output logic [7:0] rx);
        rx = 8'h00;
        CHIP_SELECT_LOW = 1'b0;
        wait_clk(4);
        for (int i = 0; i < bits; i++) begin
            SCLK = 1'b0;
            SDI = tx[7-i];
            wait_clk(8);
            SCLK = 1'b1;
            rx[7-i] = SDO;
            wait_clk(8);
        end
        // select may rise between whole bytes
        if (gap || bits < 8) begin
            release_sel(6);
        end
    endtask
endmodule

// ===== verif/tb_adc_spi_state_register_port.sv
/*
 * Self-checking bench for the serial register port: register bank, state
 * changes, result readout and link failure, with a host model on the link.
 * Assumes: the host model file is compiled first; results come from a table.
 */
`timescale 1ns/1ns
module tb_adc_spi_state_register_port;
    import adc_spi_pkg::*;
    logic CLK, NRST, SCLK, CHIP_SELECT_LOW, SDI, SDO, SDO_OE;
    logic MEASURE_STATE, TRACK, POWER_OFF, LINK_FAILED;
    logic [RESULT_W-1:0] RESULT_DATA;
    logic [1:0] RESULT_CHAN;
    logic [7:0] CONFIG_CTRL, CHANNEL_SEQUENCE, prev_raddr, rx;
    logic [23:0] GAIN_SELECT;
    logic [3:0] CHANNEL_POWERDOWN;
    logic [RESULT_W-1:0] result_tab [4];
    logic [7:0] reg_exp [16];
    logic [7:0] raddr_list [5] = '{8'h01, ADDR_STATE_CTRL, ADDR_APIGEN, 8'h0F, ADDR_CHSEQ};
    logic [7:0] meas_addr [7] = '{8'h00, 8'h00, 8'h06, 8'h00, 8'h00, 8'h00, 8'h0C};
    // entry 5 carries a reserved state code, which must leave the state alone
    logic [7:0] meas_val [7] = '{8'h00, 8'h00, 8'h77, 8'h80, 8'h43, 8'h05, 8'hE4};
    logic meas_e, track_e, poweroff_e;
    int fails, checks_done, slot;
    integer seed = 32'h5BD9;

    initial begin
        CLK = 1'b0;
        forever #5 CLK = ~CLK;
    end

    // result follows the requested channel, driven off the sampling edge
    always @(negedge CLK) RESULT_DATA <= result_tab[RESULT_CHAN];

    adc_spi_host_model u_host (.CLK(CLK), .SCLK(SCLK), .CHIP_SELECT_LOW(CHIP_SELECT_LOW),
        .SDI(SDI), .SDO(SDO));

    adc_spi_state_register_port u_dut (.CLK(CLK), .NRST(NRST), .SCLK(SCLK),
        .CHIP_SELECT_LOW(CHIP_SELECT_LOW), .SDI(SDI), .RESULT_DATA(RESULT_DATA), .SDO(SDO),
        .SDO_OE(SDO_OE), .MEASURE_STATE(MEASURE_STATE), .TRACK(TRACK), .POWER_OFF(POWER_OFF),
        .LINK_FAILED(LINK_FAILED), .RESULT_CHAN(RESULT_CHAN), .CONFIG_CTRL(CONFIG_CTRL),
        .GAIN_SELECT(GAIN_SELECT), .CHANNEL_POWERDOWN(CHANNEL_POWERDOWN),
        .CHANNEL_SEQUENCE(CHANNEL_SEQUENCE));

    // ==========================================================
    // reporting
    task automatic chk_vec(input string name, input logic [23:0] exp, input logic [23:0] got);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %0h seen %0h", name, exp, got);
        end
    endtask

    task automatic conclude();
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ==========================================================
    // expected register bank
    function automatic logic [7:0] mask_of(input logic [7:0] a);
        if (a == ADDR_CONFIG || a == ADDR_CHSEQ) return 8'hFF;
        if (a >= ADDR_GAIN0 && a <= ADDR_GAIN3) return 8'h3F;
        if (a == ADDR_CHPD) return 8'h0F;
        return 8'h00;
    endfunction

    function automatic logic [7:0] read_exp(input logic [7:0] a);
        if (a == ADDR_APIGEN) return APIGEN_VALUE;
        return reg_exp[a[3:0]] & mask_of(a);
    endfunction

    task automatic reset_exp();
        foreach (reg_exp[i]) reg_exp[i] = 8'h00;
        reg_exp[6] = CONFIG_RESET;
        for (int i = 7; i <= 10; i++) reg_exp[i] = {2'h0, GAIN_RESET};
        reg_exp[11] = {4'h0, CHPD_RESET};
        reg_exp[12] = CHSEQ_RESET;
    endtask

    // state codes other than config and measure leave the state alone
    task automatic apply_write(input logic [7:0] waddr, input logic [7:0] wval);
        if (waddr == ADDR_STATE_CTRL) begin
            track_e = wval[TRACK_BIT];
            poweroff_e = wval[POWER_OFF_BIT];
            if (wval[2:0] == STATE_CODE_MEASURE && !meas_e) begin
                meas_e = 1'b1;
                slot = 0;
            end else if (wval[2:0] == STATE_CODE_CONFIG && meas_e) begin
                meas_e = 1'b0;
                reset_exp();
            end
        end else if (!meas_e && mask_of(waddr) != 8'h00) begin
            reg_exp[waddr[3:0]] = wval & mask_of(waddr);
        end
    endtask

    // called only while select stands high, so the data output is released
    task automatic check_state();
        chk_vec("sdo_oe", 24'h0, 24'(SDO_OE));
        chk_vec("measure_state", 24'(meas_e), 24'(MEASURE_STATE));
        chk_vec("track", 24'(track_e & meas_e), 24'(TRACK));
        chk_vec("power_off", 24'(poweroff_e), 24'(POWER_OFF));
        chk_vec("config_ctrl", 24'(reg_exp[6]), 24'(CONFIG_CTRL));
        for (int i = 0; i < 4; i++) begin
            chk_vec("gain_select", 24'(reg_exp[7+i]), 24'(GAIN_SELECT[6*i +: 6]));
        end
        chk_vec("channel_powerdown", 24'(reg_exp[11]), 24'(CHANNEL_POWERDOWN));
        chk_vec("channel_sequence", 24'(reg_exp[12]), 24'(CHANNEL_SEQUENCE));
    endtask

    // ==========================================================
    // transfer cycles with random select gaps between bytes
    task automatic cfg_cycle(input logic [7:0] waddr, input logic [7:0] wval,
                             input logic [7:0] raddr, input bit chk0);
        logic [7:0] exp0;
        exp0 = read_exp(prev_raddr);
        u_host.xfer(waddr, 1'($random(seed)), 8, rx);
        if (chk0) chk_vec("cfg_byte0", 24'(exp0), 24'(rx));
        u_host.xfer(wval, 1'($random(seed)), 8, rx);
        chk_vec("cfg_byte1", 24'h0, 24'(rx));
        u_host.xfer(raddr, 1'($random(seed)), 8, rx);
        chk_vec("cfg_byte2", 24'h0, 24'(rx));
        u_host.release_sel(16);
        apply_write(waddr, wval);
        prev_raddr = raddr;
        check_state();
    endtask

    task automatic meas_cycle(input logic [7:0] waddr, input logic [7:0] wval);
        logic [1:0] ch;
        ch = reg_exp[12][7-2*slot -: 2];
        chk_vec("result_chan", 24'(ch), 24'(RESULT_CHAN));
        u_host.xfer(waddr, 1'($random(seed)), 8, rx);
        chk_vec("result_hi", 24'({4'h0, result_tab[ch][11:8]}), 24'(rx));
        u_host.xfer(wval, 1'b1, 8, rx);
        chk_vec("result_lo", 24'(result_tab[ch][7:0]), 24'(rx));
        u_host.release_sel(16);
        slot = (waddr == ADDR_STATE_CTRL && wval[TRACK_BIT]) ? 0 : (slot + 1) % 4;
        apply_write(waddr, wval);
        check_state();
    endtask

    // ==========================================================
    // main sequence
    initial begin
        NRST = 1'b0;
        fails = 0;
        checks_done = 0;
        meas_e = 1'b0;
        track_e = 1'b0;
        poweroff_e = 1'b0;
        slot = 0;
        prev_raddr = 8'h00;
        reset_exp();
        for (int i = 0; i < 4; i++) result_tab[i] = 12'($random(seed));
        repeat (10) @(negedge CLK);
        NRST = 1'b1;
        repeat (4) @(negedge CLK);
        check_state();
        // random values into every read-write register, read back next cycle
        for (int a = 6; a <= 12; a++) begin
            cfg_cycle(8'(a), 8'($random(seed)), 8'(a), 1'b1);
        end
        // reserved, write-only, read-only and sequence register reads
        foreach (raddr_list[i]) begin
            cfg_cycle(8'h01, 8'($random(seed)), raddr_list[i], 1'b1);
        end
        cfg_cycle(ADDR_STATE_CTRL, 8'h43, ADDR_CONFIG, 1'b1);
        foreach (meas_addr[i]) meas_cycle(meas_addr[i], meas_val[i]);
        meas_cycle(ADDR_STATE_CTRL, 8'h02);
        // read address from before measurement still stands and sees the default
        cfg_cycle(ADDR_CHPD, 8'($random(seed)), ADDR_CHPD, 1'b1);
        // select released mid-byte fails the link for good
        u_host.xfer(ADDR_CONFIG, 1'b1, 3, rx);
        chk_vec("link_failed", 24'h1, 24'(LINK_FAILED));
        for (int i = 0; i < 3; i++) begin
            u_host.xfer(8'h06, 1'b0, 8, rx);
            chk_vec("failed_sdo", 24'h0, 24'(rx));
            chk_vec("sdo_oe_on", 24'h1, 24'(SDO_OE));
        end
        u_host.release_sel(16);
        chk_vec("config_ctrl", 24'(reg_exp[6]), 24'(CONFIG_CTRL));
        conclude();
    end

    // watchdog well beyond the expected run length
    initial begin
        #600000;
        fails++;
        conclude();
    end
endmodule

// ===== verilog/adc_spi_pkg.sv
/*
 * Shared constants and types for the serial register port of the
 * four-channel current-input converter.
 * Assumes: one 100 MHz system clock; the serial link is sampled by it.
 */
package adc_spi_pkg;

    // ========================================================
    // register offsets
    localparam logic [7:0] ADDR_STATE_CTRL = 8'h00;
    localparam logic [7:0] ADDR_APIGEN = 8'h02;
    localparam logic [7:0] ADDR_CONFIG = 8'h06;
    localparam logic [7:0] ADDR_GAIN0 = 8'h07;
    localparam logic [7:0] ADDR_GAIN1 = 8'h08;
    localparam logic [7:0] ADDR_GAIN2 = 8'h09;
    localparam logic [7:0] ADDR_GAIN3 = 8'h0A;
    localparam logic [7:0] ADDR_CHPD = 8'h0B;
    localparam logic [7:0] ADDR_CHSEQ = 8'h0C;

    // ========================================================
    // values after reset
    localparam logic [7:0] CONFIG_RESET = 8'hA0;
    localparam logic [5:0] GAIN_RESET = 6'h01;
    localparam logic [3:0] CHPD_RESET = 4'h0;
    localparam logic [7:0] CHSEQ_RESET = 8'h1B;
    // arbitrary neutral value, not tied to any real part
    localparam logic [7:0] APIGEN_VALUE = 8'h5A;
    // sync stages reset to idle link: data 0, select high, clock high
    localparam logic [2:0] SYNC_RESET = 3'h3;

    // ========================================================
    // operating state register fields
    localparam int TRACK_BIT = 7;
    localparam int POWER_OFF_BIT = 6;
    localparam logic [2:0] STATE_CODE_NOP = 3'h0;
    localparam logic [2:0] STATE_CODE_CONFIG = 3'h2;
    localparam logic [2:0] STATE_CODE_MEASURE = 3'h3;

    // ========================================================
    // framing
    localparam logic [1:0] LAST_BYTE_CONFIG = 2'h2;
    localparam logic [1:0] LAST_BYTE_MEASURE = 2'h1;
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam int RESULT_W = 12;
    localparam logic [3:0] RESULT_PAD = 4'h0;

    typedef enum logic {MODE_CONFIG, MODE_MEASURE} mode_t;

endpackage

// ===== verilog/adc_spi_state_register_port.sv
/*
 * Serial target port of a four-channel converter: register bank,
 * configuration/measurement state machine and result shift-out.
 * Assumes: SCLK well below CLK/4; converter logic on CLK presents the
 * result for RESULT_CHAN on RESULT_DATA.
 */
`timescale 1ns/1ns
module adc_spi_state_register_port (
    input wire logic CLK, // system clock, 100 MHz
    input wire logic NRST, // synchronous reset, active low
    input wire logic SCLK, // serial clock from host, idles high
    input wire logic CHIP_SELECT_LOW, // chip select, active low
    input wire logic SDI, // serial data in
    input wire logic [adc_spi_pkg::RESULT_W-1:0] RESULT_DATA, // result for RESULT_CHAN
    output logic SDO, // serial data out
    output logic SDO_OE, // high while SDO is driven
    output logic MEASURE_STATE, // high in measurement state
    output logic TRACK, // tracking requested, measurement only
    output logic POWER_OFF, // whole-device power down
    output logic LINK_FAILED, // sticky framing failure
    output logic [1:0] RESULT_CHAN, // channel whose result is shifted out
    output logic [7:0] CONFIG_CTRL, // configuration register
    output logic [23:0] GAIN_SELECT, // four 6-bit gain fields, ch0 lowest
    output logic [3:0] CHANNEL_POWERDOWN, // per-channel power down
    output logic [7:0] CHANNEL_SEQUENCE // readout order
);
    import adc_spi_pkg::*;

    // ========================================================
    // state
    typedef struct packed {
        mode_t mode;
        mode_t next_mode;
        logic failed;
        logic sclk_prev;
        logic cs_prev;
        logic [2:0] bit_cnt;
        logic [1:0] byte_idx;
        logic [7:0] shreg;
        logic [7:0] wr_addr;
        logic [7:0] rd_addr;
        logic track;
        logic power_off;
        logic [7:0] config_ctrl;
        logic [3:0][5:0] gain;
        logic [3:0] channel_powerdown;
        logic [7:0] ch_seq;
        logic [1:0] slot;
        logic [1:0] chan;
        logic track_out;
        logic meas_out;
        logic sdo;
        logic sdo_oe;
    } state_t;

    localparam state_t ST_RESET = '{
        mode: MODE_CONFIG, next_mode: MODE_CONFIG, failed: 1'b0,
        sclk_prev: 1'b1, cs_prev: 1'b1, bit_cnt: 3'h0, byte_idx: 2'h0,
        shreg: 8'h00, wr_addr: 8'h00, rd_addr: 8'h00, track: 1'b0,
        power_off: 1'b0, config_ctrl: CONFIG_RESET, gain: {4{GAIN_RESET}},
        channel_powerdown: CHPD_RESET, ch_seq: CHSEQ_RESET, slot: 2'h0, chan: 2'h0,
        track_out: 1'b0, meas_out: 1'b0, sdo: 1'b0, sdo_oe: 1'b0};

    state_t st_q;
    state_t st_d;
    logic [2:0] sync_q;
    logic sclk_s;
    logic cs_s;
    logic sdi_s;
    logic sclk_rise;
    logic sclk_fall;
    logic byte_done;
    logic [7:0] byte_in;
    logic [7:0] tx_byte;

    // ========================================================
    // decoding helpers
    // read mux of the bank; the state register reads as zero
    function automatic logic [7:0] read_reg(input logic [7:0] addr, input state_t s);
        logic [7:0] r;
        r = 8'h00;
        unique case (addr)
            ADDR_APIGEN: r = APIGEN_VALUE;
            ADDR_CONFIG: r = s.config_ctrl;
            ADDR_GAIN0: r = {2'h0, s.gain[0]};
            ADDR_GAIN1: r = {2'h0, s.gain[1]};
            ADDR_GAIN2: r = {2'h0, s.gain[2]};
            ADDR_GAIN3: r = {2'h0, s.gain[3]};
            ADDR_CHPD: r = {4'h0, s.channel_powerdown};
            ADDR_CHSEQ: r = s.ch_seq;
            default: r = 8'h00;
        endcase
        return r;
    endfunction

    // slot 0 takes the top pair of the sequence register
    function automatic logic [1:0] chan_of(input logic [7:0] seq, input logic [1:0] slot);
        logic [2:0] pos;
        pos = {slot, 1'b0};
        return seq[3'h7 - pos -: 2];
    endfunction

    // ========================================================
    // link input synchronisers
    adc_spi_sync2 u_sync (
        .CLK(CLK),
        .NRST(NRST),
        .d({SDI, CHIP_SELECT_LOW, SCLK}),
        .q(sync_q)
    );

    assign sclk_s = sync_q[0];
    assign cs_s = sync_q[1];
    assign sdi_s = sync_q[2];

    // edge detect
    // edges are found on the synchronised clock, so SCLK must stay slow
    assign sclk_rise = sclk_s && !st_q.sclk_prev;
    assign sclk_fall = !sclk_s && st_q.sclk_prev;
    assign byte_done = sclk_rise && !cs_s && !st_q.failed && st_q.bit_cnt == LAST_BIT;
    assign byte_in = {st_q.shreg[6:0], sdi_s};

    // ========================================================
    // outgoing byte selection
    always_comb begin
        tx_byte = 8'h00;
        if (st_q.failed) begin
            tx_byte = 8'h00;
        end else if (st_q.mode == MODE_CONFIG) begin
            if (st_q.byte_idx == 2'h0) begin
                tx_byte = read_reg(st_q.rd_addr, st_q);
            end
        end else begin
            if (st_q.byte_idx == 2'h0) begin
                tx_byte = {RESULT_PAD, RESULT_DATA[RESULT_W-1:8]};
            end else begin
                tx_byte = RESULT_DATA[7:0];
            end
        end
    end

    // ========================================================
    // next state
    always_comb begin
        logic last;
        last = 1'b0;
        st_d = st_q;
        st_d.sclk_prev = sclk_s;
        st_d.cs_prev = cs_s;
        st_d.sdo_oe = !cs_s;
        // broken byte
        // a select release mid-byte is fatal until reset; no resync is attempted
        if (cs_s && !st_q.cs_prev && st_q.bit_cnt != 3'h0) begin
            st_d.failed = 1'b1;
            st_d.bit_cnt = 3'h0;
        end
        if (sclk_fall && !cs_s) begin
            st_d.sdo = tx_byte[LAST_BIT - st_q.bit_cnt];
        end
        if (sclk_rise && !cs_s && !st_q.failed) begin
            st_d.shreg = byte_in;
            st_d.bit_cnt = st_q.bit_cnt + 3'h1;
        end
        if (byte_done) begin
            last = st_q.byte_idx ==
                (st_q.mode == MODE_CONFIG ? LAST_BYTE_CONFIG : LAST_BYTE_MEASURE);
            unique case (st_q.byte_idx)
                2'h0: st_d.wr_addr = byte_in;
                2'h1: begin
                    if (st_q.wr_addr == ADDR_STATE_CTRL) begin
                        st_d.track = byte_in[TRACK_BIT];
                        st_d.power_off = byte_in[POWER_OFF_BIT];
                        if (byte_in[2:0] == STATE_CODE_CONFIG) begin
                            st_d.next_mode = MODE_CONFIG;
                        end else if (byte_in[2:0] == STATE_CODE_MEASURE) begin
                            st_d.next_mode = MODE_MEASURE;
                        end
                    end else if (st_q.mode == MODE_CONFIG) begin
                        unique case (st_q.wr_addr)
                            ADDR_CONFIG: st_d.config_ctrl = byte_in;
                            ADDR_GAIN0: st_d.gain[0] = byte_in[5:0];
                            ADDR_GAIN1: st_d.gain[1] = byte_in[5:0];
                            ADDR_GAIN2: st_d.gain[2] = byte_in[5:0];
                            ADDR_GAIN3: st_d.gain[3] = byte_in[5:0];
                            ADDR_CHPD: st_d.channel_powerdown = byte_in[3:0];
                            ADDR_CHSEQ: st_d.ch_seq = byte_in;
                            default: st_d.ch_seq = st_q.ch_seq;
                        endcase
                    end
                end
                2'h2: st_d.rd_addr = byte_in;
                2'h3: st_d.rd_addr = st_q.rd_addr;
            endcase
            st_d.byte_idx = last ? 2'h0 : st_q.byte_idx + 2'h1;
            if (last) begin
                if (st_q.mode == MODE_MEASURE) begin
                    st_d.slot = st_d.track ? 2'h0 : st_q.slot + 2'h1;
                end
                if (st_q.mode == MODE_MEASURE && st_d.next_mode == MODE_CONFIG) begin
                    st_d.config_ctrl = CONFIG_RESET;
                    st_d.gain = {4{GAIN_RESET}};
                    st_d.channel_powerdown = CHPD_RESET;
                    st_d.ch_seq = CHSEQ_RESET;
                end
                if (st_q.mode == MODE_CONFIG) begin
                    st_d.slot = 2'h0;
                end
                // mode changes only at cycle end
                st_d.mode = st_d.next_mode;
            end
        end
        st_d.chan = chan_of(st_d.ch_seq, st_d.slot);
        st_d.track_out = st_d.track && st_d.mode == MODE_MEASURE;
        st_d.meas_out = st_d.mode == MODE_MEASURE;
    end

    // ========================================================
    // registers
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            st_q <= ST_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    // all outputs are direct flop copies
    assign SDO = st_q.sdo;
    assign SDO_OE = st_q.sdo_oe;
    assign MEASURE_STATE = st_q.meas_out;
    assign TRACK = st_q.track_out;
    assign POWER_OFF = st_q.power_off;
    assign LINK_FAILED = st_q.failed;
    assign RESULT_CHAN = st_q.chan;
    assign CONFIG_CTRL = st_q.config_ctrl;
    assign GAIN_SELECT = st_q.gain;
    assign CHANNEL_POWERDOWN = st_q.channel_powerdown;
    assign CHANNEL_SEQUENCE = st_q.ch_seq;

    // ========================================================
    // checks
    property p_msb_first;
        @(posedge CLK) disable iff (!NRST)
        (sclk_fall && !cs_s && !st_q.failed && st_q.bit_cnt == 3'h0)
            |=> (SDO == $past(tx_byte[7]));
    endproperty
    a_msb_first: assert property (p_msb_first) else $error("first bit out is not bit 7");

    property p_mid_byte_fail;
        @(posedge CLK) disable iff (!NRST)
        (cs_s && !st_q.cs_prev && st_q.bit_cnt != 3'h0) |=> LINK_FAILED ##1 LINK_FAILED;
    endproperty
    a_mid_byte_fail: assert property (p_mid_byte_fail) else $error("broken byte not failed");

    property p_gap_keeps_pos;
        @(posedge CLK) disable iff (!NRST)
        (cs_s && !st_q.cs_prev && st_q.bit_cnt == 3'h0) |=> $stable(st_q.byte_idx);
    endproperty
    a_gap_keeps_pos: assert property (p_gap_keeps_pos) else $error("select gap lost position");

    property p_enter_measure;
        @(posedge CLK) disable iff (!NRST)
        (byte_done && st_q.mode == MODE_CONFIG && st_q.byte_idx == 2'h1
            && st_q.wr_addr == ADDR_STATE_CTRL && byte_in[2:0] == STATE_CODE_MEASURE)
            |=> !MEASURE_STATE ##[1:200] MEASURE_STATE || LINK_FAILED;
    endproperty
    a_enter_measure: assert property (p_enter_measure) else $error("measure code ignored");

    property p_back_to_defaults;
        @(posedge CLK) disable iff (!NRST)
        ($fell(st_q.meas_out) && !st_q.mode)
            |-> CONFIG_CTRL == CONFIG_RESET && CHANNEL_SEQUENCE == CHSEQ_RESET;
    endproperty
    a_back_to_defaults: assert property (p_back_to_defaults) else $error("bank not reset");

    property p_measure_blocks;
        @(posedge CLK) disable iff (!NRST)
        (byte_done && st_q.mode == MODE_MEASURE && st_q.wr_addr != ADDR_STATE_CTRL)
            |=> $stable(CONFIG_CTRL) && $stable(GAIN_SELECT) && $stable(CHANNEL_SEQUENCE);
    endproperty
    a_measure_blocks: assert property (p_measure_blocks) else $error("bank written in measure");

    property p_state_unreadable;
        @(posedge CLK) disable iff (!NRST)
        (st_q.mode == MODE_CONFIG && st_q.byte_idx == 2'h0 && !st_q.failed
            && (st_q.rd_addr == ADDR_STATE_CTRL || st_q.rd_addr > ADDR_CHSEQ))
            |-> tx_byte == 8'h00;
    endproperty
    a_state_unreadable: assert property (p_state_unreadable) else $error("nonzero read");

    property p_seq_reset;
        @(posedge CLK)
        !NRST |=> CHANNEL_SEQUENCE == CHSEQ_RESET && !MEASURE_STATE && !POWER_OFF;
    endproperty
    a_seq_reset: assert property (p_seq_reset) else $error("bad reset values");

    property p_track_only_measure;
        @(posedge CLK) disable iff (!NRST)
        TRACK |-> MEASURE_STATE;
    endproperty
    a_track_only_measure: assert property (p_track_only_measure) else $error("track in config");

    property p_order;
        @(posedge CLK) disable iff (!NRST)
        $rose(MEASURE_STATE) |-> RESULT_CHAN == CHANNEL_SEQUENCE[7:6];
    endproperty
    a_order: assert property (p_order) else $error("channel order wrong");

endmodule

// ===== verilog/adc_spi_sync2.sv
/*
 * Two-stage synchroniser for the three serial link inputs.
 * Assumes: inputs are asynchronous to CLK; reset is synchronous, low.
 */
`timescale 1ns/1ns
module adc_spi_sync2 (
    input wire logic CLK, // system clock
    input wire logic NRST, // synchronous reset, active low
    input wire logic [2:0] d, // asynchronous inputs
    output logic [2:0] q // synchronised copy
);
    import adc_spi_pkg::*;

    typedef struct packed {
        logic [2:0] s1_q;
        logic [2:0] s2_q;
    } sync_t;

    sync_t st_q;
    sync_t st_d;

    // first stage feeds only the second stage
    always_comb begin
        st_d = st_q;
        st_d.s1_q = d;
        st_d.s2_q = st_q.s1_q;
    end

    // ========================================================
    // registers
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            st_q <= {SYNC_RESET, SYNC_RESET};
        end else begin
            st_q <= st_d;
        end
    end

    assign q = st_q.s2_q;

endmodule
